// File: hdcr_pkg.sv
/*
 * Package for the hub device configuration register: offsets, field
 * positions, reset values and the register access carrier.
 * Assumes a single 25 MHz core clock; every user names items by scope.
 */
// Operation
// [R1] register at offset 5h, defined reset
// [R2] bit 7 gates string register writes
// [R3] bit 6 gates serial register writes
// [R4] bit 5 set disables U1/U2
// [R5] forced accept re-enables U1/U2 until reset/disconnect
// [R6] bit 4 reads as one
// [R7] bit 3 captures gang strap at release
// [R8] bit 3 selects ganged or per-port power; the code gangs only while bit 2 is clear, per-port otherwise
// [R9] bit 2 captures report strap at release
// [R10] EEPROM load overwrites bits 5,3,2
// [R11] SMBus host may write bits 5,3,2
// [R12] bit 1 forces nonzero timeouts to FFh
// [R13] bit 0 reads as zero
// [R14] blocked string writes leave contents unchanged
`default_nettype none
package hdcr_pkg;
   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [7:0] hdcr_device_configuration_offset = 8'h05;
   localparam logic [7:0] hdcr_reset_value = 8'h10;
   localparam int hdcr_string_en_bit = 7;
   localparam int hdcr_serial_en_bit = 6;
   localparam int hdcr_lpm_off_bit = 5;
   localparam int hdcr_fixed_one_bit = 4;
   localparam int hdcr_gang_bit = 3;
   localparam int hdcr_report_bit = 2;
   localparam int hdcr_timeout_ovr_bit = 1;
   localparam logic [7:0] hdcr_rw_mask = 8'he2;
   localparam logic [7:0] hdcr_load_mask = 8'h2c;
   localparam logic [7:0] hdcr_timeout_max = 8'hff;
   localparam int hdcr_num_ports = 4;

   // ************************************************************
   // register access carrier
   // ************************************************************
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } hdcr_access_t;
endpackage : hdcr_pkg
`default_nettype wire

// File: hdcr_strap_capture.sv
/*
 * Strap capture: takes the two strap levels once, on the first clock
 * after reset release. Assumes straps are stable around release.
 */
`timescale 1ns/1ps
`default_nettype none
module hdcr_strap_capture (
   input wire logic clk,
   input wire logic nrst,
   input wire logic gang_select_strap_pin,
   input wire logic report_select_strap_pin,
   output logic done,
   output logic gang,
   output logic report_off
);
   // ************************************************************
   // capture after release
   // ************************************************************
   // async reset loads constants only; pins sampled on a clock edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         done <= 1'b0;
         gang <= 1'b0;
         report_off <= 1'b0;
      end else if (!done) begin
         done <= 1'b1;
         gang <= gang_select_strap_pin;
         report_off <= report_select_strap_pin;
      end
   end
endmodule // hdcr_strap_capture
`default_nettype wire

// File: hdcr_device_config.sv
/*
 * Device configuration register (offset 5h) of the hub register space,
 * with its effects: string/serial write gating, U1/U2 gate with the
 * forced accept escape, power switch routing and timeout override.
 * Assumes the EEPROM loader and SMBus slave present one-cycle requests
 * synchronous to clk, and strap pins stable at reset release.
 */
`timescale 1ns/1ps
`default_nettype none
module hdcr_device_config #(
   parameter int num_ports = hdcr_pkg::hdcr_num_ports
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic i2c_mode,
   input wire hdcr_pkg::hdcr_access_t eeprom_load,
   input wire hdcr_pkg::hdcr_access_t smbus_acc,
   input wire logic gang_select_strap_pin,
   input wire logic report_select_strap_pin,
   input wire logic string_wr_req,
   input wire logic serial_wr_req,
   input wire logic force_accept_lmp,
   input wire logic upstream_disconnect,
   input wire logic [num_ports-1:0] port_power_req,
   input wire logic [7:0] sw_u1_timeout,
   input wire logic [7:0] sw_u2_timeout,
   input wire logic reg09_bit6,
   output logic [7:0] rdata,
   output logic string_wr_en,
   output logic serial_wr_en,
   output logic link_lpm_allowed,
   output logic power_status_report_off,
   output logic [num_ports-1:0] port_power_control_pins,
   output logic [7:0] eff_u1_timeout,
   output logic [7:0] eff_u2_timeout
);
   logic [7:0] cfg_q;
   logic [7:0] cfg_d;
   logic forced_q;
   logic strap_done;
   logic strap_done_q;
   logic strap_gang;
   logic strap_report;
   logic eep_hit;
   logic smb_hit;
   logic strap_edge;
   logic [7:0] eep_val;
   logic [7:0] smb_val;
   logic [7:0] wr_val;
   logic [7:0] view;
   logic [num_ports-1:0] pwr_route;
   logic ovr_on;

   // nonzero timeouts saturate, zero stays zero
   function automatic logic [7:0] hdcr_ovr_timeout(input logic [7:0] t, input logic on);
      return (on && t != 8'h00) ? hdcr_pkg::hdcr_timeout_max : t;
   endfunction

   // register hit: a write strobe aimed at this register's offset
   function automatic logic hdcr_hit(input hdcr_pkg::hdcr_access_t acc);
      return acc.wr && (acc.addr == hdcr_pkg::hdcr_device_configuration_offset);
   endfunction

   // replace the masked bits of v by those of d, keep the rest
   function automatic logic [7:0] hdcr_merge(input logic [7:0] v, input logic [7:0] d, input logic [7:0] m);
      return (v & ~m) | (d & m);
   endfunction

   // drop the two strap levels into their field positions
   function automatic logic [7:0] hdcr_strap_merge(input logic [7:0] v, input logic g, input logic r);
      logic [7:0] m;
      m = v;
      m[hdcr_pkg::hdcr_gang_bit] = g;
      m[hdcr_pkg::hdcr_report_bit] = r;
      return m;
   endfunction

   // ************************************************************
   // strap capture
   // ************************************************************
   hdcr_strap_capture u_strap (
      .clk(clk),
      .nrst(nrst),
      .gang_select_strap_pin(gang_select_strap_pin),
      .report_select_strap_pin(report_select_strap_pin),
      .done(strap_done),
      .gang(strap_gang),
      .report_off(strap_report)
   );

   // ************************************************************
   // write decode and next value
   // ************************************************************
   // [R1] register decode at 5h
   assign eep_hit = i2c_mode && hdcr_hit(eeprom_load);
   assign smb_hit = !i2c_mode && hdcr_hit(smbus_acc);
   // one-cycle pulse on the edge after the straps were taken
   assign strap_edge = strap_done && !strap_done_q;

   // [R10] EEPROM overwrites 5,3,2
   assign eep_val = hdcr_merge(cfg_q, eeprom_load.wdata, hdcr_pkg::hdcr_load_mask);
   // [R11] SMBus host write
   assign smb_val = hdcr_merge(cfg_q, smbus_acc.wdata, hdcr_pkg::hdcr_rw_mask | hdcr_pkg::hdcr_load_mask);
   // modes are exclusive by i2c_mode, so the order of the two hits is moot
   assign wr_val = eep_hit ? eep_val : (smb_hit ? smb_val : cfg_q);
   // [R7] [R9] strap capture
   // straps win bits 3,2 in the capture cycle only; other bits of a write landing then still stick
   assign cfg_d = strap_edge ? hdcr_strap_merge(wr_val, strap_gang, strap_report) : wr_val;

   // ************************************************************
   // register state
   // ************************************************************
   // [R1] defined reset value
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg_q <= hdcr_pkg::hdcr_reset_value;
         strap_done_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         strap_done_q <= strap_done;
      end
   end

   // [R5] forced accept latch; event wins over disconnect clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         forced_q <= 1'b0;
      end else if (force_accept_lmp) begin
         forced_q <= 1'b1;
      end else if (upstream_disconnect) begin
         forced_q <= 1'b0;
      end
   end

   // ************************************************************
   // read view and derived controls
   // ************************************************************
   // [R6] bit 4 reads one, [R13] bit 0 reads zero
   assign view = {cfg_q[7:5], 1'b1, cfg_q[3:1], 1'b0};

   // [R8] ganged routes request of any port to port 1 pin
   assign pwr_route = (!cfg_q[hdcr_pkg::hdcr_report_bit] && cfg_q[hdcr_pkg::hdcr_gang_bit])
                    ? {{(num_ports-1){1'b0}}, |port_power_req} : port_power_req;

   // [R12] override only with register 09h bit 6
   assign ovr_on = cfg_q[hdcr_pkg::hdcr_timeout_ovr_bit] && reg09_bit6;

   // ************************************************************
   // output registers
   // ************************************************************
   // read view registered, so a write shows two edges after it is taken
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= hdcr_pkg::hdcr_reset_value;
      end else begin
         rdata <= view;
      end
   end

   // [R2] [R14] string writes gated
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         string_wr_en <= 1'b0;
      end else begin
         string_wr_en <= cfg_q[hdcr_pkg::hdcr_string_en_bit] && string_wr_req;
      end
   end

   // [R3] [R14] serial writes gated
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         serial_wr_en <= 1'b0;
      end else begin
         serial_wr_en <= cfg_q[hdcr_pkg::hdcr_serial_en_bit] && serial_wr_req;
      end
   end

   // [R4] [R5] U1/U2 gate with escape
   // raw event ored in so the link is let through one cycle sooner than the latch allows
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         link_lpm_allowed <= 1'b1;
      end else begin
         link_lpm_allowed <= !cfg_q[hdcr_pkg::hdcr_lpm_off_bit] || forced_q || force_accept_lmp;
      end
   end

   // [R9] report level follows the register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         power_status_report_off <= 1'b0;
      end else begin
         power_status_report_off <= cfg_q[hdcr_pkg::hdcr_report_bit];
      end
   end

   // [R8] port power pins from the route
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         port_power_control_pins <= '0;
      end else begin
         port_power_control_pins <= pwr_route;
      end
   end

   // [R12] timeout saturation
   // values pass through untouched while the override is off
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         eff_u1_timeout <= 8'h00;
         eff_u2_timeout <= 8'h00;
      end else begin
         eff_u1_timeout <= hdcr_ovr_timeout(sw_u1_timeout, ovr_on);
         eff_u2_timeout <= hdcr_ovr_timeout(sw_u2_timeout, ovr_on);
      end
   end
endmodule // hdcr_device_config
`default_nettype wire

// File: hdcr_device_config_checker.sv
/* Checker for the device configuration register at its ports.
   Assumes one clock and the bind at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
module hdcr_device_config_checker #(
   parameter int num_ports = 4
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic i2c_mode,
   input wire hdcr_pkg::hdcr_access_t eeprom_load,
   input wire hdcr_pkg::hdcr_access_t smbus_acc,
   input wire logic string_wr_req,
   input wire logic serial_wr_req,
   input wire logic force_accept_lmp,
   input wire logic [num_ports-1:0] port_power_req,
   input wire logic [7:0] rdata,
   input wire logic string_wr_en,
   input wire logic serial_wr_en,
   input wire logic link_lpm_allowed,
   input wire logic [num_ports-1:0] port_power_control_pins
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // writes show on rdata two edges after being taken
   chk_fixed_bits: assert property (rdata[4] && !rdata[0])
      else $error("fixed bits wrong");
   chk_host_write: assert property (!i2c_mode && smbus_acc.wr && smbus_acc.addr == 8'h05
      |-> ##2 rdata == (($past(smbus_acc.wdata, 2) & 8'hee) | 8'h10)) else $error("host write lost");
   chk_rom_load: assert property (i2c_mode && eeprom_load.wr && eeprom_load.addr == 8'h05
      |-> ##2 (rdata & 8'h2c) == ($past(eeprom_load.wdata, 2) & 8'h2c)) else $error("load lost");
   // gate uses the value that rdata shows one edge later
   chk_string_gate: assert property (1'b1 |=> string_wr_en == ($past(string_wr_req) && rdata[7]))
      else $error("string gate wrong");
   chk_serial_gate: assert property (1'b1 |=> serial_wr_en == ($past(serial_wr_req) && rdata[6]))
      else $error("serial gate wrong");
   chk_gang_route: assert property (($stable(rdata) && $stable(port_power_req))[*2] ##0 rdata[3:2] == 2'b10
      |-> port_power_control_pins == num_ports'(|port_power_req)) else $error("ganged pins wrong");
   chk_port_route: assert property (($stable(rdata) && $stable(port_power_req))[*2] ##0 rdata[3:2] != 2'b10
      |-> port_power_control_pins == port_power_req) else $error("port pins wrong");
   chk_forced_lpm: assert property (force_accept_lmp |-> ##[1:3] link_lpm_allowed)
      else $error("forced accept ignored");
endmodule // hdcr_device_config_checker
bind hdcr_device_config hdcr_device_config_checker #(.num_ports(num_ports)) u_chk (.clk, .nrst, .i2c_mode,
   .eeprom_load, .smbus_acc, .string_wr_req, .serial_wr_req, .force_accept_lmp, .port_power_req, .rdata,
   .string_wr_en, .serial_wr_en, .link_lpm_allowed, .port_power_control_pins);
`default_nettype wire

// File: hdcr_cfg_source_model.sv
/* Host or serial memory loader giving one-cycle register writes.
   Assumes callers start just after a rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module hdcr_cfg_source_model (
   input wire logic clk,
   output var hdcr_pkg::hdcr_access_t eeprom_load,
   output var hdcr_pkg::hdcr_access_t smbus_acc
);
   initial begin
      eeprom_load = '{1'b0, 8'h00, 8'h00};
      smbus_acc = '{1'b0, 8'h00, 8'h00};
   end
   // released fields are inverted so stale values never look valid
   task automatic put(input logic rom, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      if (rom) eeprom_load = '{1'b1, a, d};
      else smbus_acc = '{1'b1, a, d};
      @(posedge clk);
      #1;
      eeprom_load = '{1'b0, ~a, ~d};
      smbus_acc = '{1'b0, ~a, ~d};
   endtask
endmodule // hdcr_cfg_source_model
`default_nettype wire

// File: hdcr_device_config_tb_top.sv
/* Self-checking bench for the configuration register.
   Assumes the source model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module hdcr_device_config_tb_top;
   logic clk, nrst, i2c_mode, gang_select_strap_pin, report_select_strap_pin, string_wr_req, serial_wr_req;
   logic force_accept_lmp, upstream_disconnect, reg09_bit6, string_wr_en, serial_wr_en, link_lpm_allowed;
   logic power_status_report_off;
   logic [3:0] port_power_req, port_power_control_pins;
   logic [7:0] sw_u1_timeout, sw_u2_timeout, rdata, eff_u1_timeout, eff_u2_timeout;
   logic [31:0] seed, r;
   hdcr_pkg::hdcr_access_t eeprom_load, smbus_acc;
   int failures, checks_done, cfg, forced;
   hdcr_cfg_source_model u_src (.clk, .eeprom_load, .smbus_acc);
   hdcr_device_config #(.num_ports(4)) u_dut (.clk, .nrst, .i2c_mode, .eeprom_load, .smbus_acc,
      .gang_select_strap_pin, .report_select_strap_pin, .string_wr_req, .serial_wr_req, .force_accept_lmp,
      .upstream_disconnect, .port_power_req, .sw_u1_timeout, .sw_u2_timeout, .reg09_bit6, .rdata,
      .string_wr_en, .serial_wr_en, .link_lpm_allowed, .power_status_report_off, .port_power_control_pins,
      .eff_u1_timeout, .eff_u2_timeout);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] tmo(input logic [7:0] t);
      return (cfg[1] && reg09_bit6 && t != 8'h00) ? 8'hff : t;
   endfunction
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // reset with given straps, then read back the captured levels
   task automatic rst(input logic [1:0] s);
      {gang_select_strap_pin, report_select_strap_pin} = s;
      port_power_req = 4'h0;
      nrst = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("reset rdata", 8'h10, rdata);
      nrst = 1'b1;
      cfg = {4'h1, s, 2'b00};
      forced = 0;
      repeat (3) @(posedge clk);
      #1;
      chk("strap rdata", cfg[7:0], rdata);
   endtask
   // one write with fresh side inputs, then every derived output
   task automatic step(input logic rom, input logic [7:0] a, input logic [7:0] d);
      r = rnd();
      {reg09_bit6, port_power_req} = r[4:0];
      sw_u1_timeout = r[5] ? r[15:8] : 8'h00;
      sw_u2_timeout = r[23:16];
      u_src.put(rom, a, d);
      if (a == 8'h05 && rom === i2c_mode) cfg = rom ? (cfg & 8'hd3) | (d & 8'h2c) : (d & 8'hee) | 8'h10;
      repeat (3) @(posedge clk);
      #1;
      chk("rdata", cfg[7:0], rdata);
      chk("pins", cfg[3:2] == 2'b10 ? {7'h0, |port_power_req} : {4'h0, port_power_req}, {4'h0, port_power_control_pins});
      chk("lpm", {7'h0, !cfg[5] || forced != 0}, {7'h0, link_lpm_allowed});
      chk("report", {7'h0, cfg[2]}, {7'h0, power_status_report_off});
      chk("u1", tmo(sw_u1_timeout), eff_u1_timeout);
      chk("u2", tmo(sw_u2_timeout), eff_u2_timeout);
      {string_wr_req, serial_wr_req} = 2'b11;
      @(posedge clk);
      #1;
      {string_wr_req, serial_wr_req} = 2'b00;
      chk("gates", {6'h0, cfg[7:6]}, {6'h0, string_wr_en, serial_wr_en});
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // bench drives 1 ns after each rising edge
   initial begin
      {nrst, i2c_mode, string_wr_req, serial_wr_req, force_accept_lmp, upstream_disconnect} = 6'h00;
      {reg09_bit6, sw_u1_timeout, sw_u2_timeout} = 17'h0;
      seed = 32'h9154;
      failures = 0;
      checks_done = 0;
      rst(2'b11);
      $display("test strap reset done");
      for (int i = 0; i < 24; i++) begin
         if (i == 12) i2c_mode = 1'b1;
         step(i % 4 == 3 ? ~i2c_mode : i2c_mode, i % 4 == 2 ? 8'h06 : 8'h05, 8'(rnd()));
      end
      $display("test write and load done");
      i2c_mode = 1'b0;
      step(1'b0, 8'h05, 8'h20);
      force_accept_lmp = 1'b1;
      forced = 1;
      step(1'b0, 8'h06, 8'h00);
      force_accept_lmp = 1'b0;
      upstream_disconnect = 1'b1;
      forced = 0;
      step(1'b0, 8'h06, 8'h00);
      upstream_disconnect = 1'b0;
      $display("test forced accept done");
      rst(2'b01);
      step(1'b0, 8'h05, 8'(rnd()));
      $display("test second reset done");
      complete_run();
   end
endmodule // hdcr_device_config_tb_top
`default_nettype wire
